// ===== iprc_input_pll_receiver_config_regs.sv
// input pll charge pump and receiver configuration register bank
// Summary of operation
// - charge pump tristate bit set forces the pump output to high impedance.
// - seven-bit field sets pump current, about half a microamp per step.
// - override clear forces high antibacklash; set lets the width field choose.
// - antibacklash width decodes 00 min, 01 low, 10 high, 11 max; resets high.
// - pump mode decodes 00 tristate, 01 up, 10 down, 11 normal.
// - test reference receiver enabled when its bit is one; off after reset.
// - secondary reference differential when bit set, else single-ended with pin select.
// - primary reference differential when bit set, else single-ended with pin select.
// - power-down control clear keeps both receivers on; set uses per-receiver enables.
// - oscillator single-ended select one picks negative pin, zero picks positive.
// - oscillator receiver differential when its bit is one, else single-ended.
// - feedback bit one uses oscillator receiver; zero uses zero-delay path.
// - zero-delay mode honoured only with feedback bit zero; selects internal or external.
// - zero-delay receiver differential when its bit is one, else single-ended.
// - zero-delay pin select honoured only while that receiver is single-ended.
// - secondary reference pin select honoured only while its differential bit is zero.
// - primary reference pin select honoured only while its differential bit is zero.
`timescale 1ns/1ps
module iprc_input_pll_receiver_config_regs
	import iprc_pkg::*;
(
	// clock and reset
	input wire logic mclk,
	input wire logic srst,
	// register access from the serial control port
	input wire logic [9:0] reg_addr,
	input wire logic reg_wr,
	input wire logic [7:0] reg_wdata,
	output logic [7:0] reg_rdata,
	// input pll charge pump controls
	output logic cp_tristate,
	output logic [6:0] cp_current,
	output iprc_cp_mode_type cp_mode,
	output logic [1:0] abl_width,
	// reference receivers
	output logic test_ref_enable,
	output logic primary_reference_enable,
	output logic primary_reference_diff,
	output logic primary_reference_se_sel,
	output logic secondary_reference_enable,
	output logic secondary_reference_diff,
	output logic secondary_reference_se_sel,
	// oscillator input receiver
	output logic oscillator_input_diff,
	output logic oscillator_input_neg_sel,
	// feedback and zero-delay receiver
	output logic fb_from_oscillator,
	output logic zero_delay_input_enable,
	output logic zero_delay_internal,
	output logic zero_delay_input_diff,
	output logic zero_delay_input_se_sel
);
	// ********************************
	// register storage
	// ********************************
	logic [7:0] cp_current_q;
	logic [7:0] cp_mode_q;
	logic [7:0] rx_ctrl_q;
	logic [7:0] fb_se_q;
	logic hit_cp_current;
	logic hit_cp_mode;
	logic hit_rx_ctrl;
	logic hit_fb_se;

	// address decode of the four registers
	assign hit_cp_current = (reg_addr == IPRC_ADDR_CP_CURRENT);
	assign hit_cp_mode = (reg_addr == IPRC_ADDR_CP_MODE);
	assign hit_rx_ctrl = (reg_addr == IPRC_ADDR_RX_CTRL);
	assign hit_fb_se = (reg_addr == IPRC_ADDR_FB_SE);

	// one register instance per address; masks hold reserved bits at zero
	iprc_reg8 #(.RESET_VALUE(IPRC_RST_CP_CURRENT), .WRITE_MASK(IPRC_MASK_CP_CURRENT)) u_cp_current (
		.mclk(mclk),
		.srst(srst),
		.wr_en(reg_wr & hit_cp_current),
		.wr_data(reg_wdata),
		.value(cp_current_q)
	);
	iprc_reg8 #(.RESET_VALUE(IPRC_RST_CP_MODE), .WRITE_MASK(IPRC_MASK_CP_MODE)) u_cp_mode (
		.mclk(mclk),
		.srst(srst),
		.wr_en(reg_wr & hit_cp_mode),
		.wr_data(reg_wdata),
		.value(cp_mode_q)
	);
	iprc_reg8 #(.RESET_VALUE(IPRC_RST_RX_CTRL), .WRITE_MASK(IPRC_MASK_RX_CTRL)) u_rx_ctrl (
		.mclk(mclk),
		.srst(srst),
		.wr_en(reg_wr & hit_rx_ctrl),
		.wr_data(reg_wdata),
		.value(rx_ctrl_q)
	);
	iprc_reg8 #(.RESET_VALUE(IPRC_RST_FB_SE), .WRITE_MASK(IPRC_MASK_FB_SE)) u_fb_se (
		.mclk(mclk),
		.srst(srst),
		.wr_en(reg_wr & hit_fb_se),
		.wr_data(reg_wdata),
		.value(fb_se_q)
	);

	// ********************************
	// read back
	// ********************************
	logic [7:0] rdata_next;
	logic [7:0] rdata_reg;

	// unmapped addresses read zero
	assign rdata_next = hit_cp_current ? cp_current_q :
		hit_cp_mode ? cp_mode_q :
		hit_rx_ctrl ? rx_ctrl_q :
		hit_fb_se ? fb_se_q : 8'h00;

	// registered so read data comes from flip-flops
	always_ff @(posedge mclk) begin
		if (srst) begin
			rdata_reg <= 8'h00;
		end else begin
			rdata_reg <= rdata_next;
		end
	end
	assign reg_rdata = rdata_reg;

	// ********************************
	// charge pump decode
	// ********************************
	logic [1:0] abl_field;
	logic abl_override;
	logic [1:0] abl_next;

	assign cp_tristate = cp_current_q[IPRC_BIT_CP_TRISTATE];
	assign cp_current = cp_current_q[6:0];
	assign cp_mode = iprc_cp_mode_type'(cp_mode_q[IPRC_POS_CP_MODE +: 2]);

	// automatic high setting until software takes control
	assign abl_field = cp_mode_q[IPRC_POS_ABL_WIDTH +: 2];
	assign abl_override = cp_mode_q[IPRC_BIT_ABL_OVERRIDE];
	assign abl_next = abl_override ? abl_field : IPRC_ABL_HIGH;
	assign abl_width = abl_next;

	// ********************************
	// reference receiver decode
	// ********************************
	logic pd_ctrl;
	logic pri_diff;
	logic sec_diff;

	assign test_ref_enable = rx_ctrl_q[IPRC_BIT_TEST_EN];
	assign pd_ctrl = rx_ctrl_q[IPRC_BIT_PD_CTRL];
	// without power-down control both receivers stay on regardless of their enables
	assign primary_reference_enable = ~pd_ctrl | rx_ctrl_q[IPRC_BIT_PRI_EN];
	assign secondary_reference_enable = ~pd_ctrl | rx_ctrl_q[IPRC_BIT_SEC_EN];

	assign pri_diff = rx_ctrl_q[IPRC_BIT_PRI_DIFF];
	assign sec_diff = rx_ctrl_q[IPRC_BIT_SEC_DIFF];
	assign primary_reference_diff = pri_diff;
	assign secondary_reference_diff = sec_diff;
	// pin select is gated off in differential mode so the analog side sees a clean zero
	assign primary_reference_se_sel = ~pri_diff & fb_se_q[IPRC_BIT_PRI_SEL];
	assign secondary_reference_se_sel = ~sec_diff & fb_se_q[IPRC_BIT_SEC_SEL];

	// ********************************
	// oscillator input decode
	// ********************************
	assign oscillator_input_diff = rx_ctrl_q[IPRC_BIT_OSC_DIFF];
	assign oscillator_input_neg_sel = ~rx_ctrl_q[IPRC_BIT_OSC_DIFF] & rx_ctrl_q[IPRC_BIT_OSC_SEL];

	// ********************************
	// feedback and zero-delay decode
	// ********************************
	logic fb_osc;
	logic zd_mode;
	logic zd_diff;

	assign fb_osc = fb_se_q[IPRC_BIT_FB_OSC];
	assign zd_mode = fb_se_q[IPRC_BIT_ZD_MODE];
	assign zd_diff = fb_se_q[IPRC_BIT_ZD_DIFF];
	assign fb_from_oscillator = fb_osc;
	// mode bit ignored once feedback comes from the oscillator receiver
	assign zero_delay_internal = ~fb_osc & zd_mode;
	assign zero_delay_input_enable = ~fb_osc & ~zd_mode;
	assign zero_delay_input_diff = zd_diff;
	assign zero_delay_input_se_sel = ~zd_diff & fb_se_q[IPRC_BIT_ZD_SEL];
endmodule

// ===== iprc_monitor.sv
// checker tying decoded outputs of the config bank to register writes
`timescale 1ns/1ps
module iprc_monitor
	import iprc_pkg::*;
(
	// clock and reset
	input wire logic mclk,
	input wire logic srst,
	// register port
	input wire logic [9:0] reg_addr,
	input wire logic reg_wr,
	input wire logic [7:0] reg_wdata,
	input wire logic [7:0] reg_rdata,
	// decoded outputs
	input wire logic cp_tristate,
	input wire iprc_cp_mode_type cp_mode,
	input wire logic [1:0] abl_width,
	input wire logic primary_reference_enable,
	input wire logic primary_reference_diff,
	input wire logic primary_reference_se_sel,
	input wire logic oscillator_input_neg_sel,
	input wire logic fb_from_oscillator,
	input wire logic zero_delay_input_enable,
	input wire logic zero_delay_internal
);
	// ****************
	// write strobes
	// ****************
	wire logic wr_pump = reg_wr && reg_addr == IPRC_ADDR_CP_CURRENT;
	wire logic wr_mode = reg_wr && reg_addr == IPRC_ADDR_CP_MODE;
	wire logic wr_rx = reg_wr && reg_addr == IPRC_ADDR_RX_CTRL;
	default clocking @(posedge mclk); endclocking
	default disable iff (srst);
	// ****************
	// properties
	// ****************
	property p_tri; wr_pump |=> cp_tristate == $past(reg_wdata[7]); endproperty
	property p_ablh; wr_mode && !reg_wdata[4] |=> abl_width == 2'h2; endproperty
	property p_abls; wr_mode && reg_wdata[4] |=> abl_width == $past(reg_wdata[3:2]); endproperty
	property p_mode; wr_mode |=> cp_mode == $past(reg_wdata[1:0]); endproperty
	property p_pd; wr_rx && !reg_wdata[2] |=> primary_reference_enable; endproperty
	property p_osc; wr_rx |=> oscillator_input_neg_sel == ($past(reg_wdata[1]) && !$past(reg_wdata[0])); endproperty
	property p_sel; primary_reference_diff |-> !primary_reference_se_sel; endproperty
	property p_zd; fb_from_oscillator |-> !zero_delay_input_enable && !zero_delay_internal; endproperty
	property p_rd; wr_pump ##1 (!reg_wr && reg_addr == IPRC_ADDR_CP_CURRENT) |=> reg_rdata == $past(reg_wdata, 2); endproperty
	a_tri: assert property (p_tri) else $error("tristate bit wrong");
	a_ablh: assert property (p_ablh) else $error("auto width wrong");
	a_abls: assert property (p_abls) else $error("width field wrong");
	a_mode: assert property (p_mode) else $error("pump mode wrong");
	a_pd: assert property (p_pd) else $error("receiver off");
	a_osc: assert property (p_osc) else $error("osc pin wrong");
	a_sel: assert property (p_sel) else $error("pin select in diff");
	a_zd: assert property (p_zd) else $error("zero delay active");
	a_rd: assert property (p_rd) else $error("readback wrong");
	c_abl: cover property (wr_mode && reg_wdata[4]);
	c_fb: cover property (fb_from_oscillator);
	c_int: cover property (zero_delay_internal);
endmodule
bind iprc_input_pll_receiver_config_regs iprc_monitor u_mon (.mclk, .srst, .reg_addr, .reg_wr, .reg_wdata,
	.reg_rdata, .cp_tristate, .cp_mode, .abl_width, .primary_reference_enable, .primary_reference_diff,
	.primary_reference_se_sel, .oscillator_input_neg_sel, .fb_from_oscillator, .zero_delay_input_enable,
	.zero_delay_internal);

// ===== iprc_pkg.sv
// package of offsets, field positions and reset values for the input pll receiver config bank
package iprc_pkg;
	// ********************************
	// register offsets
	// ********************************
	localparam logic [9:0] IPRC_ADDR_CP_CURRENT = 10'h018;
	localparam logic [9:0] IPRC_ADDR_CP_MODE = 10'h019;
	localparam logic [9:0] IPRC_ADDR_RX_CTRL = 10'h01a;
	localparam logic [9:0] IPRC_ADDR_FB_SE = 10'h01b;

	// ********************************
	// reset values
	// ********************************
	localparam logic [7:0] IPRC_RST_CP_CURRENT = 8'h00;
	localparam logic [7:0] IPRC_RST_CP_MODE = 8'h08;
	localparam logic [7:0] IPRC_RST_RX_CTRL = 8'h00;
	localparam logic [7:0] IPRC_RST_FB_SE = 8'h00;

	// ********************************
	// writable bit masks (reserved bits stay zero)
	// ********************************
	localparam logic [7:0] IPRC_MASK_CP_CURRENT = 8'hff;
	localparam logic [7:0] IPRC_MASK_CP_MODE = 8'h1f;
	localparam logic [7:0] IPRC_MASK_RX_CTRL = 8'hff;
	localparam logic [7:0] IPRC_MASK_FB_SE = 8'h3f;

	// ********************************
	// field positions
	// ********************************
	localparam int IPRC_BIT_CP_TRISTATE = 7;
	localparam int IPRC_BIT_ABL_OVERRIDE = 4;
	localparam int IPRC_POS_ABL_WIDTH = 2;
	localparam int IPRC_POS_CP_MODE = 0;
	localparam int IPRC_BIT_TEST_EN = 7;
	localparam int IPRC_BIT_SEC_DIFF = 6;
	localparam int IPRC_BIT_PRI_DIFF = 5;
	localparam int IPRC_BIT_SEC_EN = 4;
	localparam int IPRC_BIT_PRI_EN = 3;
	localparam int IPRC_BIT_PD_CTRL = 2;
	localparam int IPRC_BIT_OSC_SEL = 1;
	localparam int IPRC_BIT_OSC_DIFF = 0;
	localparam int IPRC_BIT_ZD_MODE = 5;
	localparam int IPRC_BIT_FB_OSC = 4;
	localparam int IPRC_BIT_ZD_SEL = 3;
	localparam int IPRC_BIT_ZD_DIFF = 2;
	localparam int IPRC_BIT_SEC_SEL = 1;
	localparam int IPRC_BIT_PRI_SEL = 0;

	// ********************************
	// antibacklash and pump encodings
	// ********************************
	localparam logic [1:0] IPRC_ABL_HIGH = 2'h2;

	typedef enum logic [1:0] {
		IPRC_CP_TRISTATE = 2'h0,
		IPRC_CP_UP = 2'h1,
		IPRC_CP_DOWN = 2'h2,
		IPRC_CP_NORMAL = 2'h3
	} iprc_cp_mode_type;
endpackage

// ===== iprc_reg8.sv
// one 8-bit configuration register with writable-bit mask
`timescale 1ns/1ps
module iprc_reg8 #(
	parameter logic [7:0] RESET_VALUE = 8'h00,
	parameter logic [7:0] WRITE_MASK = 8'hff
) (
	// clock and reset
	input wire logic mclk,
	input wire logic srst,
	// write side
	input wire logic wr_en,
	input wire logic [7:0] wr_data,
	// stored value
	output logic [7:0] value
);
	logic [7:0] value_reg;
	logic [7:0] value_next;

	// masked bits never change, so reserved bits read zero
	assign value_next = wr_en ? (wr_data & WRITE_MASK) : value_reg;
	assign value = value_reg;

	// storage
	always_ff @(posedge mclk) begin
		if (srst) begin
			value_reg <= RESET_VALUE & WRITE_MASK;
		end else begin
			value_reg <= value_next;
		end
	end
endmodule

// ===== test_input_pll_receiver_config_regs.sv
// self-checking bench for the input pll receiver config bank
`timescale 1ns/1ps
`define CHK(nm, e, g) begin n_checks++; if ((g) !== (e)) begin n_fail++; \
	$display("CHECK FAILED %s exp %h got %h", nm, e, g); end end
module test_input_pll_receiver_config_regs
	import iprc_pkg::*;
;
	logic mclk = 0, srst = 1, reg_wr = 0, cp_tristate, test_ref_enable, fb_from_oscillator;
	logic [9:0] reg_addr = 10'h000;
	logic [7:0] reg_wdata = 8'h00, reg_rdata;
	logic [6:0] cp_current;
	logic [1:0] abl_width;
	iprc_cp_mode_type cp_mode;
	logic primary_reference_enable, primary_reference_diff, primary_reference_se_sel;
	logic secondary_reference_enable, secondary_reference_diff, secondary_reference_se_sel;
	logic oscillator_input_diff, oscillator_input_neg_sel, zero_delay_input_enable;
	logic zero_delay_internal, zero_delay_input_diff, zero_delay_input_se_sel;
	int n_fail = 0, n_checks = 0;
	logic [7:0] m [4];
	// table rows: address then write data
	logic [17:0] rows [16] = '{{10'h018, 8'hff}, {10'h018, 8'h55}, {10'h019, 8'h01}, {10'h019, 8'h06},
		{10'h019, 8'h1a}, {10'h019, 8'hf7}, {10'h019, 8'h13}, {10'h019, 8'h17}, {10'h019, 8'h10},
		{10'h01a, 8'hac}, {10'h01a, 8'h57}, {10'h01a, 8'h02}, {10'h01b, 8'h2b}, {10'h01b, 8'h1c},
		{10'h01b, 8'hff}, {10'h01c, 8'hff}};
	wire logic [25:0] got = {cp_tristate, cp_current, cp_mode, abl_width, test_ref_enable, primary_reference_enable,
		primary_reference_diff, primary_reference_se_sel, secondary_reference_enable, secondary_reference_diff,
		secondary_reference_se_sel, oscillator_input_diff, oscillator_input_neg_sel, fb_from_oscillator,
		zero_delay_input_enable, zero_delay_internal, zero_delay_input_diff, zero_delay_input_se_sel};
	iprc_input_pll_receiver_config_regs u_dut (.*);
	// expected decode worked out from the bench's own register image
	function automatic logic [25:0] ex();
		logic [7:0] c, p, r, f;
		c = m[0]; p = m[1]; r = m[2]; f = m[3];
		return {c, p[1:0], p[4] ? p[3:2] : 2'h2, r[7], ~r[2] | r[3], r[5], ~r[5] & f[0], ~r[2] | r[4], r[6],
			~r[6] & f[1], r[0], ~r[0] & r[1], f[4], ~f[4] & ~f[5], ~f[4] & f[5], f[2], ~f[2] & f[3]};
	endfunction
	function automatic logic mapped(input logic [9:0] a);
		return a >= 10'h018 && a <= 10'h01b;
	endfunction
	// ****************
	// bus tasks
	// ****************
	task automatic wr(input logic [9:0] a, input logic [7:0] d);
		@(negedge mclk); reg_wr = 1; reg_addr = a; reg_wdata = d;
		if (mapped(a)) m[a[1:0]] = d & (a[1:0] == 2'h1 ? 8'h1f : a[1:0] == 2'h3 ? 8'h3f : 8'hff);
	endtask
	task automatic rd(input logic [9:0] a);
		@(negedge mclk); reg_wr = 0; reg_addr = a;
		@(negedge mclk);
		`CHK("rdata", mapped(a) ? m[a[1:0]] : 8'h00, reg_rdata)
		`CHK("decode", ex(), got)
	endtask
	task automatic rst();
		@(negedge mclk); srst = 1; reg_wr = 0;
		repeat (3) @(negedge mclk);
		srst = 0; m = '{8'h00, 8'h08, 8'h00, 8'h00};
		for (int i = 0; i < 5; i++) rd(i < 4 ? 10'h018 + 10'(i) : 10'h000);
		$display("reset test done");
	endtask
	task automatic results();
		$display("checks %0d failures %0d", n_checks, n_fail);
		if (n_fail == 0 && n_checks > 0) $display("RESULT: PASS");
		else $display("RESULT: FAIL");
		$finish;
	endtask
	// clock at 25 MHz
	initial begin
		forever #20 mclk = ~mclk;
	end
	// watchdog well past the expected run of about 90 cycles
	initial begin
		repeat (2000) @(posedge mclk);
		n_fail++;
		results();
	end
	initial begin
		rst();
		foreach (rows[i]) begin
			wr(rows[i][17:8], rows[i][7:0]);
			rd(rows[i][17:8]);
		end
		$display("table test done");
		// back to back writes, last one wins; unmapped write in between
		wr(10'h018, 8'h80); wr(10'h3ff, 8'h55); wr(10'h01b, 8'h09); wr(10'h018, 8'h7f);
		rd(10'h018); rd(10'h01b); rd(10'h3ff);
		$display("back to back test done");
		// every pin select set while all receivers are differential: selects must read zero
		wr(10'h01b, 8'h0f); wr(10'h01a, 8'h63);
		rd(10'h01a);
		$display("differential gating test done");
		// reset in mid run restores defaults
		rst();
		results();
	end
endmodule
